// ---- arith_cfg.svh ----
// address map, widths, reset values and timing counts of the arithmetic unit
`ifndef ARITH_CFG_SVH
`define ARITH_CFG_SVH

// ************************************************************
// register addresses on the second register page
// ************************************************************
`define OPA_B0_ADDR   8'hA2
`define OPA_B1_ADDR   8'hA3
`define ADD_B0_ADDR   8'hA4
`define ADD_B1_ADDR   8'hA5
`define ADD_B2_ADDR   8'hA6
`define ADD_B3_ADDR   8'hA7
`define DIV_TRIG_ADDR 8'hB1
`define OPB_B0_ADDR   8'hB2
`define OPB_B1_ADDR   8'hB3
`define RES_B0_ADDR   8'hB4
`define RES_B1_ADDR   8'h05
`define RES_B2_ADDR   8'hB6
`define RES_B3_ADDR   8'hB7
`define PRV_B0_ADDR   8'hC4
`define PRV_B1_ADDR   8'hC5
`define PRV_B2_ADDR   8'hC6
`define PRV_B3_ADDR   8'hC7

// ************************************************************
// reset values and fixed patterns
// ************************************************************
`define ZERO8         8'h00
`define ZERO16        16'h0000
`define ZERO32        32'h0000_0000
`define MIN16         16'h8000
`define ALL1_16       16'hFFFF

// ************************************************************
// barrel shifter and divider timing
// ************************************************************
`define SHIFT_LIMIT   6'h10
`define DIV_CYCLES    3'h5
`define DIV_DONE_CNT  (`DIV_CYCLES - 3'h1)
`define CNT_ONE       3'h1

`endif

// ---- arith_pkg.sv ----
// shared types of the arithmetic unit
package arith_pkg;

  // divider sequencer states
  typedef enum logic [0:0] {
    DIV_IDLE = 1'b0,
    DIV_RUN  = 1'b1
  } div_state_t;

  // multiplier second factor select
  typedef enum logic [1:0] {
    MUL_A_B    = 2'b00,
    MUL_A_A    = 2'b01,
    MUL_A_PREV = 2'b10,
    MUL_A_B2   = 2'b11
  } mul_cmd_t;

  // adder term select
  typedef enum logic [1:0] {
    ADD_NONE   = 2'b00,
    ADD_C      = 2'b01,
    ADD_PREV   = 2'b10,
    ADD_CAT_C  = 2'b11
  } add_src_t;

endpackage

// ---- div_if.sv ----
// carrier between the register set and the divider
`timescale 1ns/100ps
interface div_if;
  logic        start;      // one-cycle request
  logic [15:0] dividend;   // signed dividend
  logic [15:0] divisor;    // signed divisor
  logic [15:0] quotient;   // valid with done
  logic [15:0] remainder;  // valid with done
  logic        done;       // one-cycle completion
  logic        busy;       // division in flight

  // register side
  modport ctrl (output start, dividend, divisor,
                input  quotient, remainder, done, busy);
  // divider side
  modport unit (input  start, dividend, divisor,
                output quotient, remainder, done, busy);
endinterface : div_if

// ---- div_core.sv ----
// five-cycle signed 16-bit divider
`timescale 1ns/100ps
`include "arith_cfg.svh"
module div_core (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  // request and answer
  div_if.unit       dv
);

  arith_pkg::div_state_t state;     // sequencer
  logic [2:0]            cnt;       // cycles since start
  logic [15:0]           num;       // latched dividend
  logic [15:0]           den;       // latched divisor
  logic                  bad;       // out-of-range operands
  logic [15:0]           q_calc;    // combinational quotient
  logic [15:0]           r_calc;    // combinational remainder

  // zero divisor or most-negative by minus one cannot be represented
  assign bad    = (den == `ZERO16) || ((num == `MIN16) && (den == `ALL1_16));
  assign q_calc = bad ? `ALL1_16 : 16'($signed(num) / $signed(den));
  assign r_calc = bad ? num : 16'($signed(num) % $signed(den));
  assign dv.busy = (state == arith_pkg::DIV_RUN);

  // ************************************************************
  // sequencer: result handed over after the fixed latency
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state        <= arith_pkg::DIV_IDLE;
      cnt          <= 3'h0;
      num          <= `ZERO16;
      den          <= `ZERO16;
      dv.quotient  <= `ZERO16;
      dv.remainder <= `ZERO16;
      dv.done      <= 1'b0;
    end else begin
      dv.done <= 1'b0;
      if (dv.start) begin
        // a new trigger restarts the count
        num   <= dv.dividend;
        den   <= dv.divisor;
        cnt   <= `CNT_ONE;
        state <= arith_pkg::DIV_RUN;
      end else begin
        unique case (state)
          arith_pkg::DIV_IDLE: begin
            cnt <= 3'h0;
          end
          arith_pkg::DIV_RUN: begin
            cnt <= cnt + `CNT_ONE;
            if (cnt == `DIV_DONE_CNT) begin
              dv.quotient  <= q_calc;
              dv.remainder <= r_calc;
              dv.done      <= 1'b1;
              state        <= arith_pkg::DIV_IDLE;
            end
          end
        endcase
      end
    end
  end

endmodule // div_core

// ---- arith_unit_operand_result_regs.sv ----
// operand, result and previous-result registers of the arithmetic unit
`timescale 1ns/100ps
`include "arith_cfg.svh"
module arith_unit_operand_result_regs (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,

  // register port from the core
  input  wire logic       page_sel_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  output logic      [7:0] sfr_rdata_out,

  // control bits held by the control registers
  input  wire logic       capture_mode_sel_in,
  input  wire logic       capture_now_in,
  input  wire logic       result_view_sel_in,
  input  wire logic [1:0] mul_cmd_in,
  input  wire logic [1:0] add_src_in,
  input  wire logic [5:0] shift_amt_in,
  input  wire logic       arith_shift_in,

  // status
  output logic            div_mode_out,
  output logic            div_busy_out
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // replace one byte lane of a 32-bit word
  function automatic logic [31:0] put_byte(input logic [31:0] w,
                                           input logic [1:0]  lane,
                                           input logic [7:0]  b);
    logic [31:0] r;

    r = w;
    r[lane*8 +: 8] = b;
    return r;
  endfunction

  // pick one byte lane of a 32-bit word
  function automatic logic [7:0] get_byte(input logic [31:0] w,
                                          input logic [1:0]  lane);
    return w[lane*8 +: 8];
  endfunction

  // signed shift, positive left, negative right, clamped to the range
  function automatic logic [31:0] barrel(input logic [31:0] v,
                                         input logic [5:0]  amt,
                                         input logic        keep_sign);
    logic [5:0]  mag;
    logic [31:0] l;

    mag = amt[5] ? 6'(-amt) : amt;
    if (mag > `SHIFT_LIMIT) begin
      mag = `SHIFT_LIMIT;
    end

    l = v << mag;

    if (!amt[5]) begin
      // arithmetic left keeps the sign bit in place
      return keep_sign ? {v[31], l[30:0]} : l;
    end

    return 32'($signed(v) >>> mag);
  endfunction

  // ************************************************************
  // storage
  // ************************************************************
  logic [15:0] operand_a;        // first factor / upper add half
  logic [15:0] operand_b;        // second factor / lower add half
  logic [31:0] addend_c;         // addition operand

  logic [31:0] result_reg;       // latest outcome, read-only
  logic [31:0] previous_result;  // saved outcome for feedback

  logic        div_mode;         // division owns result_reg

  // carrier to the divider
  div_if div_bus ();

  // ************************************************************
  // write decode
  // ************************************************************
  logic wr_hit;     // write on the arithmetic page
  logic wr_a0;      // operand_a low byte
  logic wr_a1;      // operand_a high byte
  logic wr_c_any;   // one of the addend bytes

  logic wr_trig;    // divisor low byte with trigger
  logic wr_b0;      // operand_b low byte, no trigger
  logic wr_b1;      // operand_b high byte

  logic [1:0] c_lane;  // addend byte lane addressed

  // registers are decoded only on the second page
  assign wr_hit   = sfr_wr_in && page_sel_in;
  assign wr_a0    = wr_hit && (sfr_addr_in == `OPA_B0_ADDR);
  assign wr_a1    = wr_hit && (sfr_addr_in == `OPA_B1_ADDR);

  assign wr_trig  = wr_hit && (sfr_addr_in == `DIV_TRIG_ADDR);
  assign wr_b0    = wr_hit && (sfr_addr_in == `OPB_B0_ADDR);
  assign wr_b1    = wr_hit && (sfr_addr_in == `OPB_B1_ADDR);

  assign wr_c_any = wr_hit && (sfr_addr_in >= `ADD_B0_ADDR)
                           && (sfr_addr_in <= `ADD_B3_ADDR);

  // lane is the low two address bits, A4H being lane zero
  assign c_lane   = sfr_addr_in[1:0];

  // ************************************************************
  // datapath: multiply, add, shift
  // ************************************************************
  logic [15:0] mul_second;   // chosen second factor
  logic [31:0] product;      // signed 16x16 product

  logic [31:0] add_term;     // chosen added term
  logic [31:0] left_term;    // product or concatenation
  logic [31:0] sum;          // adder output

  logic [31:0] shifted;      // barrel shifter output

  logic        cat_mode;     // 32-bit addition selected

  assign cat_mode = (add_src_in == arith_pkg::ADD_CAT_C);

  // second factor; both 00 and 11 multiply a by b
  assign mul_second = (mul_cmd_in == arith_pkg::MUL_A_A)    ? operand_a :
                      (mul_cmd_in == arith_pkg::MUL_A_PREV) ? previous_result[15:0] :
                      operand_b;
  // signed multiply of the two 16-bit factors
  assign product = 32'($signed(operand_a) * $signed(mul_second));

  // concatenation uses a as the upper half
  assign left_term = cat_mode ? {operand_a, operand_b} : product;

  // added term: nothing, addend, or the saved result
  assign add_term = (add_src_in == arith_pkg::ADD_NONE) ? `ZERO32 :
                    (add_src_in == arith_pkg::ADD_PREV) ? previous_result :
                    addend_c;

  // sum wraps at 32 bits; no overflow flag is produced
  assign sum = left_term + add_term;

  // the shifter sits in front of result_reg
  assign shifted = barrel(sum, shift_amt_in, arith_shift_in);

  // ************************************************************
  // divider request
  // ************************************************************
  // dividend a, divisor is high byte plus the byte being written
  assign div_bus.start    = wr_trig;
  assign div_bus.dividend = operand_a;
  assign div_bus.divisor  = {operand_b[15:8], sfr_wdata_in};

  // five-cycle divider
  div_core u_div (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .dv          (div_bus)
  );

  // ************************************************************
  // previous-result capture decision
  // ************************************************************
  logic cap_auto;    // operand_a low byte write in auto mode
  logic cap_manual;  // capture_now in manual mode

  logic cap_go;      // copy result_reg this edge

  assign cap_auto   = wr_a0 && !capture_mode_sel_in;
  assign cap_manual = capture_now_in && capture_mode_sel_in;

  assign cap_go     = cap_auto || cap_manual;

  // ************************************************************
  // next result value
  // ************************************************************
  logic [31:0] next_result;  // value for result_reg

  // divide result arrives unshifted and holds in division mode; otherwise track the datapath
  assign next_result = div_bus.done ? {div_bus.quotient, div_bus.remainder} :
                       div_mode     ? result_reg :
                       shifted;

  // ************************************************************
  // operand registers
  // ************************************************************
  // operand_a bytes, read/write
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      operand_a <= `ZERO16;
    end else if (wr_a0) begin
      operand_a[7:0] <= sfr_wdata_in;
    end else if (wr_a1) begin
      operand_a[15:8] <= sfr_wdata_in;
    end
  end

  // operand_b bytes; the trigger byte also lands in the low byte
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      operand_b <= `ZERO16;
    end else if (wr_b0 || wr_trig) begin
      operand_b[7:0] <= sfr_wdata_in;
    end else if (wr_b1) begin
      operand_b[15:8] <= sfr_wdata_in;
    end
  end

  // addend bytes, low byte at the lowest address
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addend_c <= `ZERO32;
    end else if (wr_c_any) begin
      addend_c <= put_byte(addend_c, c_lane, sfr_wdata_in);
    end
  end

  // ************************************************************
  // mode, result and previous result
  // ************************************************************
  // division mode holds until a plain operand_b low write
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_mode <= 1'b0;
    end else if (wr_trig) begin
      div_mode <= 1'b1;
    end else if (wr_b0) begin
      div_mode <= 1'b0;
    end
  end

  // result_reg has no write path from software
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result_reg <= `ZERO32;
    end else begin
      result_reg <= next_result;
    end
  end

  // the copy uses the registered value, so a capture on the same
  // edge as an operand_a low write saves the old outcome
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      previous_result <= `ZERO32;
    end else if (cap_go) begin
      previous_result <= result_reg;
    end
  end

  // ************************************************************
  // read decode
  // ************************************************************
  logic        rd_hit;     // read on the arithmetic page
  logic [31:0] res_view;   // result bytes source

  logic [7:0]  rd_data;    // selected byte

  assign rd_hit = sfr_rd_in && page_sel_in;

  // result reads may show the saved outcome instead
  assign res_view = result_view_sel_in ? previous_result : result_reg;

  // unmapped addresses read as zero
  assign rd_data =
    // operand bytes
    (sfr_addr_in == `OPA_B0_ADDR)   ? operand_a[7:0]  :
    (sfr_addr_in == `OPA_B1_ADDR)   ? operand_a[15:8] :
    (sfr_addr_in == `ADD_B0_ADDR)   ? get_byte(addend_c, 2'h0) :
    (sfr_addr_in == `ADD_B1_ADDR)   ? get_byte(addend_c, 2'h1) :
    (sfr_addr_in == `ADD_B2_ADDR)   ? get_byte(addend_c, 2'h2) :
    (sfr_addr_in == `ADD_B3_ADDR)   ? get_byte(addend_c, 2'h3) :
    (sfr_addr_in == `DIV_TRIG_ADDR) ? operand_b[7:0]  :
    (sfr_addr_in == `OPB_B0_ADDR)   ? operand_b[7:0]  :
    (sfr_addr_in == `OPB_B1_ADDR)   ? operand_b[15:8] :
    // result bytes
    (sfr_addr_in == `RES_B0_ADDR)   ? get_byte(res_view, 2'h0) :
    (sfr_addr_in == `RES_B1_ADDR)   ? get_byte(res_view, 2'h1) :
    (sfr_addr_in == `RES_B2_ADDR)   ? get_byte(res_view, 2'h2) :
    (sfr_addr_in == `RES_B3_ADDR)   ? get_byte(res_view, 2'h3) :
    // saved result bytes
    (sfr_addr_in == `PRV_B0_ADDR)   ? get_byte(previous_result, 2'h0) :
    (sfr_addr_in == `PRV_B1_ADDR)   ? get_byte(previous_result, 2'h1) :
    (sfr_addr_in == `PRV_B2_ADDR)   ? get_byte(previous_result, 2'h2) :
    (sfr_addr_in == `PRV_B3_ADDR)   ? get_byte(previous_result, 2'h3) :
    `ZERO8;

  // ************************************************************
  // output registers
  // ************************************************************
  // read data holds until the next read is taken
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= `ZERO8;
    end else if (rd_hit) begin
      sfr_rdata_out <= rd_data;
    end
  end

  // status mirrors; mode one cycle behind, busy rises with the trigger edge and falls one cycle after the divider
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_mode_out <= 1'b0;
      div_busy_out <= 1'b0;
    end else begin
      div_mode_out <= div_mode;
      div_busy_out <= div_bus.busy || div_bus.start;
    end
  end

endmodule // arith_unit_operand_result_regs

// ---- arith_regs_checker.sv ----
// timing assertions on the ports of the arithmetic unit register set
`timescale 1ns/100ps
`include "arith_cfg.svh"
module arith_regs_checker (
  // clock and reset
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  // register port
  input wire logic       page_sel_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  // control bits
  input wire logic       capture_mode_sel_in,
  input wire logic       capture_now_in,
  input wire logic       result_view_sel_in,
  input wire logic [1:0] mul_cmd_in,
  input wire logic [1:0] add_src_in,
  input wire logic [5:0] shift_amt_in,
  input wire logic       arith_shift_in,
  // status
  input wire logic       div_mode_out,
  input wire logic       div_busy_out
);
  // ************************************************************
  // decoded accesses that were really taken
  // ************************************************************
  wire logic rd_taken = sfr_rd_in && page_sel_in;                       // read on page
  wire logic trig_wr  = sfr_wr_in && page_sel_in && (sfr_addr_in == `DIV_TRIG_ADDR);
  wire logic opb_wr   = sfr_wr_in && page_sel_in && (sfr_addr_in == `OPB_B0_ADDR);

  // one domain, so clock and reset are given once
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_rd_hold; !rd_taken |=> $stable(sfr_rdata_out); endproperty
  property p_unmapped; rd_taken && (sfr_addr_in == 8'h10) |=> sfr_rdata_out == 8'h00; endproperty
  property p_busy_len; trig_wr |-> ##1 div_busy_out [*5]; endproperty
  property p_busy_end; $rose(div_busy_out) |-> ##5 !div_busy_out; endproperty
  property p_mode_set; trig_wr |-> ##2 div_mode_out; endproperty
  property p_mode_clr; opb_wr |-> ##2 !div_mode_out; endproperty
  property p_mode_cause; $rose(div_mode_out) |-> $past(trig_wr, 2); endproperty
  property p_mode_drop; $fell(div_mode_out) |-> $past(opb_wr, 2); endproperty
  // reset must clear outputs even while the other checks are off
  property p_reset;
    disable iff (1'b0) !nrst_in |=> (sfr_rdata_out == 8'h00) && !div_mode_out && !div_busy_out;
  endproperty

  a_rd_hold:    assert property (p_rd_hold) else $error("read data moved without read");
  a_unmapped:   assert property (p_unmapped) else $error("unmapped read not zero");
  a_busy_len:   assert property (p_busy_len) else $error("busy not five cycles");
  a_busy_end:   assert property (p_busy_end) else $error("busy too long");
  a_mode_set:   assert property (p_mode_set) else $error("trigger missed mode");
  a_mode_clr:   assert property (p_mode_clr) else $error("mode kept after b low");
  a_mode_cause: assert property (p_mode_cause) else $error("mode without trigger");
  a_mode_drop:  assert property (p_mode_drop) else $error("mode dropped alone");
  a_reset:      assert property (p_reset) else $error("outputs not cleared in reset");

  // main scenarios reached
  c_div:  cover property (trig_wr);
  c_view: cover property (rd_taken && result_view_sel_in);
  c_auto: cover property (sfr_wr_in && page_sel_in && !capture_mode_sel_in);
endmodule // arith_regs_checker

bind arith_unit_operand_result_regs arith_regs_checker u_chk (
  .core_clk_in, .nrst_in, .page_sel_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in,
  .sfr_rd_in, .sfr_rdata_out, .capture_mode_sel_in, .capture_now_in,
  .result_view_sel_in, .mul_cmd_in, .add_src_in, .shift_amt_in, .arith_shift_in,
  .div_mode_out, .div_busy_out);

// ---- core_bus_model.sv ----
// behavioural model of the core issuing register accesses
`timescale 1ns/100ps
module core_bus_model (
  // clock
  input  wire logic       core_clk_in,
  // register port towards the block
  output logic            page_sel_out,
  output logic      [7:0] sfr_addr_out,
  output logic      [7:0] sfr_wdata_out,
  output logic            sfr_wr_out,
  output logic            sfr_rd_out,
  input  wire logic [7:0] sfr_rdata_in
);
  // idle bus: strobes low, page one selected
  initial begin
    page_sel_out  = 1'b1;
    sfr_addr_out  = 8'h00;
    sfr_wdata_out = 8'h00;
    sfr_wr_out    = 1'b0;
    sfr_rd_out    = 1'b0;
  end
  // page is a level; the core sets it before touching the unit
  task automatic set_page(input logic p);
    @(posedge core_clk_in);
    page_sel_out <= p;
  endtask
  // one write; address and data turn to junk once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    sfr_addr_out  <= a;
    sfr_wdata_out <= d;
    sfr_wr_out    <= 1'b1;
    @(posedge core_clk_in);
    sfr_wr_out    <= 1'b0;
    sfr_addr_out  <= ~a;
    sfr_wdata_out <= ~d;
  endtask
  // one read; data is looked at once the taking edge has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    sfr_addr_out <= a;
    sfr_rd_out   <= 1'b1;
    @(posedge core_clk_in);
    sfr_rd_out   <= 1'b0;
    sfr_addr_out <= ~a;
    @(negedge core_clk_in);
    d = sfr_rdata_in;
  endtask
endmodule // core_bus_model

// ---- arith_unit_operand_result_regs_test.sv ----
// self-checking bench of the arithmetic unit register set
`timescale 1ns/100ps
`include "arith_cfg.svh"
module arith_unit_operand_result_regs_test;
  `define CHK(g, e) check(32'(g), 32'(e))
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic       core_clk_in = 1'b0;
  logic       nrst_in     = 1'b0;
  logic       cap_mode    = 1'b0;  // capture mode
  logic       cap_now     = 1'b0;  // manual capture
  logic       view_sel    = 1'b0;  // result view
  logic       arith_shift = 1'b0;
  logic [1:0] mul_cmd     = 2'h0;
  logic [1:0] add_src     = 2'h0;
  logic [5:0] shift_amt   = 6'h00;
  wire logic  page_sel, wr, rd, div_mode, div_busy;
  wire logic [7:0] addr, wdata, rdata;
  int         mismatches  = 0;
  int         check_count = 0;
  // byte lanes of result and previous result, low byte first
  localparam logic [31:0] RES_ADR = {`RES_B3_ADDR, `RES_B2_ADDR, `RES_B1_ADDR, `RES_B0_ADDR};
  localparam logic [31:0] PRV_ADR = {`PRV_B3_ADDR, `PRV_B2_ADDR, `PRV_B1_ADDR, `PRV_B0_ADDR};
  logic [7:0] op_adr [9] = '{8'hA2, 8'hA3, 8'hB2, 8'hB3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hB1};

  initial forever #2 core_clk_in = ~core_clk_in;

  core_bus_model u_core (.core_clk_in, .page_sel_out(page_sel), .sfr_addr_out(addr),
    .sfr_wdata_out(wdata), .sfr_wr_out(wr), .sfr_rd_out(rd), .sfr_rdata_in(rdata));
  arith_unit_operand_result_regs u_dut (.core_clk_in, .nrst_in, .page_sel_in(page_sel),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_rdata_out(rdata), .capture_mode_sel_in(cap_mode), .capture_now_in(cap_now),
    .result_view_sel_in(view_sel), .mul_cmd_in(mul_cmd), .add_src_in(add_src),
    .shift_amt_in(shift_amt), .arith_shift_in(arith_shift), .div_mode_out(div_mode),
    .div_busy_out(div_busy));

  // ************************************************************
  // shared helpers
  // ************************************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  // signed 16 by 16 product, worked out independently of the block
  function automatic logic [31:0] mul_s(input logic [15:0] x, input logic [15:0] y);
    return 32'($signed(x) * $signed(y));
  endfunction
  task automatic rd32(input logic [31:0] adr, output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      u_core.rd(adr[8*i +: 8], b);
      v[8*i +: 8] = b;
    end
  endtask
  task automatic chk_res(input logic [31:0] e);
    logic [31:0] v;
    rd32(RES_ADR, v);
    `CHK(v, e);
  endtask
  task automatic set_ops(input logic [15:0] a, input logic [15:0] b, input logic [31:0] c);
    logic [63:0] v;
    v = {c, b, a};
    for (int i = 0; i < 8; i++) u_core.wr(op_adr[i], v[8*i +: 8]);
  endtask
  // datapath controls change at an edge; result settles one edge later
  task automatic ctl(input logic [1:0] m, input logic [1:0] s, input logic [5:0] sh);
    @(posedge core_clk_in);
    mul_cmd   <= m;
    add_src   <= s;
    shift_amt <= sh;
    tick(2);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_values;
    logic [7:0] ad [18] = '{8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hB1, 8'hB2, 8'hB3,
      8'hB4, 8'h05, 8'hB6, 8'hB7, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'h10};
    logic [7:0] d;
    foreach (ad[i]) begin
      u_core.rd(ad[i], d);
      `CHK(d, 8'h00);
    end
    $display("reset values done");
  endtask
  task automatic t_operands;
    logic [71:0] v;
    logic [7:0]  d;
    v = {8'h11, 32'h11111111, 16'h4411, 16'h3322};
    set_ops(16'h3322, 16'h4411, 32'h11111111);
    foreach (op_adr[i]) begin
      u_core.rd(op_adr[i], d);
      `CHK(d, v[8*i +: 8]);
    end
    // off-page write must be ignored
    u_core.set_page(1'b0);
    u_core.wr(8'hA2, 8'h55);
    u_core.set_page(1'b1);
    u_core.rd(8'hA2, d);
    `CHK(d, 8'h22);
    $display("operands done");
  endtask
  task automatic t_mac;
    logic [41:0] tab [7] = '{{2'h0, 2'h0, 6'h00, 32'h0D986D42},
      {2'h1, 2'h0, 6'h00, 32'h0A369084}, {2'h3, 2'h0, 6'h00, 32'h0D986D42},
      {2'h0, 2'h1, 6'h00, 32'h1EA97E53}, {2'h0, 2'h3, 6'h00, 32'h44335522},
      {2'h0, 2'h1, 6'h01, 32'h3D52FCA6}, {2'h0, 2'h1, 6'h3E, 32'h07AA5F94}};
    foreach (tab[i]) begin
      ctl(tab[i][41:40], tab[i][39:38], tab[i][37:32]);
      chk_res(tab[i][31:0]);
    end
    u_core.wr(8'hB4, 8'hFF);
    chk_res(32'h07AA5F94);
    $display("multiply add done");
  endtask
  task automatic t_capture;
    logic [31:0] v;
    ctl(2'h0, 2'h1, 6'h00);
    u_core.wr(8'hA2, 8'h23);
    u_core.wr(8'hC4, 8'hFF);
    rd32(PRV_ADR, v);
    `CHK(v, 32'h1EA97E53);
    ctl(2'h2, 2'h0, 6'h00);
    chk_res(mul_s(16'h3323, 16'h7E53));
    ctl(2'h0, 2'h2, 6'h00);
    chk_res(mul_s(16'h3323, 16'h4411) + 32'h1EA97E53);
    tick(1);
    view_sel <= 1'b1;
    tick(2);
    chk_res(32'h1EA97E53);
    tick(1);
    view_sel <= 1'b0;
    cap_mode <= 1'b1;
    u_core.wr(8'hA2, 8'h22);
    rd32(PRV_ADR, v);
    `CHK(v, 32'h1EA97E53);
    tick(1);
    cap_now <= 1'b1;
    tick(1);
    cap_now <= 1'b0;
    rd32(PRV_ADR, v);
    `CHK(v, 32'h2C41EB95);
    $display("capture done");
  endtask
  task automatic t_div;
    logic [55:0] dv [2] = '{{16'hFF9C, 8'h07, 32'hFFF2FFFE}, {16'h0064, 8'h00, 32'hFFFF0064}};
    logic [7:0]  d;
    ctl(2'h0, 2'h1, 6'h01);
    arith_shift <= 1'b1;
    u_core.wr(8'hA3, 8'h00);
    u_core.wr(8'hA2, 8'h64);
    u_core.wr(8'hB3, 8'h00);
    u_core.wr(8'hB1, 8'h07);
    tick(4);
    @(negedge core_clk_in);
    `CHK(div_busy, 1'b1);
    @(negedge core_clk_in);
    `CHK(div_busy, 1'b0);
    chk_res(32'h000E0002);
    u_core.rd(8'hB2, d);
    `CHK({div_mode, d}, 9'h107);
    foreach (dv[i]) begin
      u_core.wr(8'hA3, dv[i][55:48]);
      u_core.wr(8'hA2, dv[i][47:40]);
      u_core.wr(8'hB1, dv[i][39:32]);
      tick(6);
      chk_res(dv[i][31:0]);
    end
    u_core.wr(8'hB2, 8'h11);
    tick(2);
    chk_res((mul_s(16'h0064, 16'h0011) + 32'h11111111) << 1);
    `CHK(div_mode, 1'b0);
    $display("division done");
  endtask

  // main sequence
  initial begin
    tick(8);
    nrst_in <= 1'b1;
    t_reset_values;
    t_operands;
    t_mac;
    t_capture;
    t_div;
    final_report;
  end
  // watchdog: the run needs well under a thousand cycles
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
endmodule // arith_unit_operand_result_regs_test
